/* File: shared/sacs_pkg.sv */
// Package of constants and types for the conversion sequencer.
// How it works
// - A conversion start turns the internal conversion clock on and clears the whole approximation register.
// - Once a conversion has begun it runs to completion and cannot be aborted or restarted.
// - While converting, the result is not driven onto the data outputs.
// - At the end of the trials the clock stops, status falls, and the result becomes readable.
// - Bits are tried one per clock from MSB to LSB, kept if the trial sum stays below the held input.
// - After the last trial the approximation register holds the full binary result.
// - A falling edge on the read/convert select input starts sampling and then conversion.
// - The first two internal clock cycles after a start acquire the input and form the aperture delay.
// - After acquisition the sample is held, the input is disconnected and the bit trials run.
// - Acquisition time is counted in internal clock cycles and so follows the clock rate.
// - Status is high only while converting, and a further start meanwhile has no effect.
// - The length-select input, latched at the start, ends after 8 bits when high or 12 bits when low.
// - Data outputs stay off unless read/convert is high, status is low, enable is high and select is low.
package sacs_pkg;

    localparam int          SACS_BITS        = 12;
    localparam int          SACS_SHORT_BITS  = 8;
    localparam int          SACS_ACQ_CYCLES  = 2;
    localparam logic [3:0]  SACS_LAST_LONG   = 4'h0;
    localparam logic [3:0]  SACS_LAST_SHORT  = 4'h4;
    localparam logic [3:0]  SACS_MSB_INDEX   = 4'hB;
    localparam logic [1:0]  SACS_ACQ_LAST    = 2'h1;
    localparam logic [11:0] SACS_SAR_RESET   = 12'h000;
    // Nominal acquisition time in nanoseconds with its spread; the logic uses the fixed SACS_ACQ_CYCLES count instead.
    localparam int          SACS_ACQ_TIME_NS = 2900;
    localparam int          SACS_ACQ_SPREAD_NS = 1100;
    localparam int          SACS_CLK_NS      = 50;

    typedef enum logic [3:0] {
        SACS_IDLE    = 4'b0001,
        SACS_ACQUIRE = 4'b0010,
        SACS_TRIAL   = 4'b0100,
        SACS_DONE    = 4'b1000
    } sacs_state_t;

    typedef struct packed {
        logic readConvert;
        logic chipEnable;
        logic chipSelectN;
        logic lengthByteSelect;
        logic twelveEightSel;
    } sacs_ctrl_t;

endpackage : sacs_pkg

/* File: src/sacs_sequencer.sv */
// Control and sequencing logic of a 12-bit successive-approximation converter.
`timescale 1ns/1ps
`default_nettype none
module sacs_sequencer
(
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                arst_n,
    // Control inputs
    input  wire sacs_pkg::sacs_ctrl_t ctrl,
    // Comparator result: high when the trial sum is below the held input
    input  wire logic                trialBelow,
    // Analog front-end controls
    output logic                     convClkEn,
    output logic                     sampleConnect,
    output logic [11:0]              capacitiveDac,
    // Status and data
    output logic                     conversionStatus,
    output logic [11:0]              dataOut,
    output logic [11:0]              dataOutEnN
);
    import sacs_pkg::*;

    sacs_state_t state_reg;
    logic        rcPrev_reg;
    logic        shortLen_reg;
    logic [1:0]  acqCnt_reg;
    logic [3:0]  bitIdx_reg;
    logic [11:0] sar_reg;
    logic [11:0] sar_next;
    logic        startEdge;
    logic        readOk;
    logic [11:0] readData;
    logic [11:0] readEnN;
    logic [3:0]  lastIdx;
    // Decoded events of the sequence, shared by the state machine and the output registers.
    sacs_state_t state_next;
    logic        startTaken;
    logic        acqLast;
    logic        lastTrial;

    // Chip enable and select must also be in their active states for a start.
    assign startEdge = rcPrev_reg && !ctrl.readConvert && ctrl.chipEnable
                       && !ctrl.chipSelectN;
    assign lastIdx = shortLen_reg ? SACS_LAST_SHORT : SACS_LAST_LONG;
    // A start only counts in idle; this one term is what keeps a running conversion intact.
    assign startTaken = (state_reg == SACS_IDLE) && startEdge;
    assign acqLast    = (state_reg == SACS_ACQUIRE) && (acqCnt_reg == SACS_ACQ_LAST);
    assign lastTrial  = (state_reg == SACS_TRIAL) && (bitIdx_reg == lastIdx);

    // History resets high, so a select held low through reset release is taken as a falling edge and starts a conversion.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            rcPrev_reg <= 1'b1;
        else
            rcPrev_reg <= ctrl.readConvert;
    end

    // Starts are only accepted in idle, so a start during a conversion is ignored.
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            SACS_IDLE:    if (startEdge) state_next = SACS_ACQUIRE;
            SACS_ACQUIRE: if (acqLast) state_next = SACS_TRIAL;
            SACS_TRIAL:   if (lastTrial) state_next = SACS_DONE;
            SACS_DONE:    state_next = SACS_IDLE;
            default:      state_next = SACS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            state_reg <= SACS_IDLE;
        else
            state_reg <= state_next;
    end

    // Only the start latches the length, so a later change of the select pin cannot alter it.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            shortLen_reg <= 1'b0;
        else if (startTaken)
            shortLen_reg <= ctrl.lengthByteSelect;
    end

    // Acquisition is counted in clock cycles, so its length in time scales with the clock rate.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            acqCnt_reg <= 2'h0;
        else if (state_reg == SACS_ACQUIRE)
            acqCnt_reg <= acqCnt_reg + 2'h1;
        else
            acqCnt_reg <= 2'h0;
    end

    // The index reloads whenever no trial runs, so every conversion begins at the MSB.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            bitIdx_reg <= SACS_MSB_INDEX;
        else if (state_reg == SACS_TRIAL)
            bitIdx_reg <= bitIdx_reg - 4'h1;
        else
            bitIdx_reg <= SACS_MSB_INDEX;
    end

    // Trial bit is set in the DAC word; the comparator decides whether it stays.
    always_comb
    begin
        sar_next = sar_reg;
        if (startTaken)
            sar_next = SACS_SAR_RESET;
        else if (state_reg == SACS_TRIAL && !trialBelow)
            sar_next[bitIdx_reg] = 1'b0;
        else if (state_reg == SACS_TRIAL)
            sar_next[bitIdx_reg] = 1'b1;
    end

    // The result stays here until the next start clears it, so it may be read many times.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            sar_reg <= SACS_SAR_RESET;
        else
            sar_reg <= sar_next;
    end

    // The DAC drives the trial word: held result plus the bit under test.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            capacitiveDac <= SACS_SAR_RESET;
        else if (acqLast)
            capacitiveDac <= 12'h800;
        else if (state_reg == SACS_TRIAL && bitIdx_reg != lastIdx)
            capacitiveDac <= sar_next | (12'h001 << (bitIdx_reg - 4'h1));
        else
            capacitiveDac <= sar_next;
    end

    // The clock enable spans exactly the conversion, so the trial logic never runs while idle.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            convClkEn <= 1'b0;
        else if (startTaken)
            convClkEn <= 1'b1;
        else if (lastTrial)
            convClkEn <= 1'b0;
    end

    // Status rises with the clock enable and falls with the last trial; reads wait on it.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            conversionStatus <= 1'b0;
        else if (startTaken)
            conversionStatus <= 1'b1;
        else if (lastTrial)
            conversionStatus <= 1'b0;
    end

    // The input is connected for the acquisition cycles only, then isolated from the trials.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            sampleConnect <= 1'b0;
        else if (startTaken)
            sampleConnect <= 1'b1;
        else if (acqLast)
            sampleConnect <= 1'b0;
    end

    // Read gating: the four conditions, then full word, upper byte or low nibble.
    always_comb
    begin
        readOk   = ctrl.readConvert && !conversionStatus && ctrl.chipEnable
                   && !ctrl.chipSelectN;
        readData = 12'h000;
        readEnN  = 12'hFFF;
        if (readOk && ctrl.twelveEightSel)
        begin
            readData = sar_reg;
            readEnN  = 12'h000;
        end
        else if (readOk && !ctrl.lengthByteSelect)
        begin
            readData = {sar_reg[11:4], 4'h0};
            readEnN  = 12'h00F;
        end
        else if (readOk)
        begin
            readData = {sar_reg[3:0], 8'h00};
            readEnN  = 12'h00F;
        end
    end

    // Registering the read path costs a cycle of latency but keeps every pin on a flip-flop.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            dataOut <= 12'h000;
        else
            dataOut <= readData;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            dataOutEnN <= 12'hFFF;
        else
            dataOutEnN <= readEnN;
    end

endmodule : sacs_sequencer
`default_nettype wire

/* File: verification/sacs_sequencer_properties.sv */
// Port checker of the conversion sequencer.
`timescale 1ns/1ps
`default_nettype none
module sacs_sequencer_properties
(
    input wire logic                 ref_clk,
    input wire logic                 arst_n,
    input wire sacs_pkg::sacs_ctrl_t ctrl,
    input wire logic                 convClkEn,
    input wire logic                 sampleConnect,
    input wire logic [11:0]          capacitiveDac,
    input wire logic                 conversionStatus,
    input wire logic [11:0]          dataOutEnN
);
    import sacs_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    wire logic picked = ctrl.chipEnable && !ctrl.chipSelectN;
    sequence go;
        $fell(ctrl.readConvert) && picked && !conversionStatus && !$past(conversionStatus);
    endsequence
    chk_start_answer:
        assert property (go |=> conversionStatus && convClkEn && sampleConnect) else $error("no start");
    chk_acq_two:
        assert property ($rose(sampleConnect) |-> ##1 sampleConnect ##1 !sampleConnect) else $error("acq");
    chk_trial_msb:
        assert property ($fell(sampleConnect) |-> capacitiveDac == 12'h800) else $error("first trial");
    chk_busy_no_data:
        assert property (conversionStatus |-> dataOutEnN == 12'hFFF) else $error("busy read");
    chk_length_long:
        assert property ((go and !ctrl.lengthByteSelect) |-> ##14 conversionStatus ##1 !conversionStatus)
        else $error("long length");
    chk_length_short:
        assert property ((go and ctrl.lengthByteSelect) |-> ##10 conversionStatus ##1 !conversionStatus)
        else $error("short length");
    chk_no_restart:
        assert property (conversionStatus |=> !$rose(sampleConnect)) else $error("restart");
    chk_clk_follows:
        assert property (convClkEn == conversionStatus) else $error("clock enable");
    chk_read_gate:
        assert property (!conversionStatus && ctrl.readConvert && picked |=> dataOutEnN != 12'hFFF)
        else $error("read gate");
    cover property (go and ctrl.lengthByteSelect);
    cover property (go and !ctrl.lengthByteSelect);
    cover property (dataOutEnN == 12'h000);
endmodule : sacs_sequencer_properties
`default_nettype wire

/* File: verification/sacs_comparator_model.sv */
// Comparator model that holds the sampled input and judges each trial word.
`timescale 1ns/1ps
`default_nettype none
module sacs_comparator_model
(
    input  wire logic        ref_clk,
    input  wire logic        sampleConnect,
    input  wire logic [11:0] capacitiveDac,
    input  wire logic [11:0] analogIn,
    output logic             trialBelow
);
    logic [11:0] heldInput;
    always_ff @(posedge ref_clk)
    begin
        if (sampleConnect)
        begin
            heldInput <= analogIn;
        end
    end
    // The input sits half a step above its code, so a trial equal to it is kept.
    assign trialBelow = capacitiveDac <= heldInput;
endmodule : sacs_comparator_model
`default_nettype wire

/* File: verification/sacs_sequencer_tb.sv */
// Self-checking testbench of the conversion sequencer.
`timescale 1ns/1ps
`default_nettype none
module sacs_sequencer_tb;
    import sacs_pkg::*;
    logic ref_clk, arst_n, trialBelow, convClkEn, sampleConnect, conversionStatus;
    sacs_ctrl_t ctrl;
    logic [11:0] capacitiveDac, dataOut, dataOutEnN, analogIn, res;
    logic [15:0] lfsrReg;
    logic [11:0] expQ[$];
    int errCount = 0, totalChecks = 0, cycles = 0;
    sacs_sequencer sacs_sequencer_inst (.ref_clk(ref_clk), .arst_n(arst_n), .ctrl(ctrl),
        .trialBelow(trialBelow), .convClkEn(convClkEn), .sampleConnect(sampleConnect),
        .capacitiveDac(capacitiveDac), .conversionStatus(conversionStatus),
        .dataOut(dataOut), .dataOutEnN(dataOutEnN));
    sacs_comparator_model sacs_comparator_model_inst (.ref_clk(ref_clk), .analogIn(analogIn),
        .sampleConnect(sampleConnect), .capacitiveDac(capacitiveDac), .trialBelow(trialBelow));
    task automatic checkWord(input string what, input logic [11:0] exp, input logic [11:0] got);
        totalChecks++;
        if (got !== exp)
        begin
            errCount++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : checkWord
    // Reference conversion from the rules: trial bits from the MSB, kept while the sum fits.
    function automatic logic [11:0] modelResult(input logic len, input logic [11:0] code);
        int acc;
        int lastBit;
        acc = 0;
        lastBit = len ? SACS_BITS - SACS_SHORT_BITS : 0;
        for (int b = SACS_BITS - 1; b >= lastBit; b--)
        begin
            if (acc + (1 << b) <= code)
                acc += 1 << b;
        end
        return acc[11:0];
    endfunction : modelResult
    function automatic logic [15:0] nextLfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nextLfsr
    task automatic completeRun;
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : completeRun
    task automatic readBack(input logic w, input logic b, input logic [11:0] d, input logic [11:0] en);
        @(posedge ref_clk);
        ctrl.readConvert <= 1'b1;
        ctrl.twelveEightSel <= w;
        ctrl.lengthByteSelect <= b;
        @(posedge ref_clk);
        #1;
        checkWord("data", d, dataOut & ~dataOutEnN);
        checkWord("enable", en, dataOutEnN);
    endtask : readBack
    task automatic convert(input logic len, input logic [11:0] code);
        @(posedge ref_clk);
        ctrl.readConvert <= 1'b0;
        ctrl.lengthByteSelect <= len;
        analogIn <= code;
        expQ.push_back(modelResult(len, code));
        repeat (5) @(posedge ref_clk);
        ctrl.readConvert <= 1'b1;
        ctrl.lengthByteSelect <= ~len;
        analogIn <= ~code;
        @(posedge ref_clk);
        ctrl.readConvert <= 1'b0;
        #1;
        checkWord("busy enable", 12'hFFF, dataOutEnN);
        repeat (len ? 6 : 10) @(posedge ref_clk);
        #1;
        checkWord("status", 12'h000, {11'h0, conversionStatus | convClkEn});
        res = expQ.pop_front();
        readBack(1'b1, 1'b0, res, 12'h000);
        readBack(1'b0, 1'b0, {res[11:4], 4'h0}, 12'h00F);
        readBack(1'b0, 1'b1, {res[3:0], 8'h00}, 12'h00F);
        $display("conversion of %h length %0d done", code, len ? 8 : 12);
    endtask : convert
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles > 3000)
        begin
            errCount++;
            completeRun();
        end
    end
    initial
    begin
        arst_n = 1'b0;
        ctrl = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        analogIn = 12'h000;
        lfsrReg = 16'hFDF6;
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        ctrl.chipSelectN <= 1'b1;
        ctrl.readConvert <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        checkWord("deselected", 12'hFFF, dataOutEnN | {11'h0, conversionStatus});
        @(posedge ref_clk);
        ctrl.chipSelectN <= 1'b0;
        ctrl.chipEnable <= 1'b0;
        ctrl.readConvert <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        checkWord("disabled", 12'hFFF, dataOutEnN | {11'h0, conversionStatus});
        $display("deselect and disable tests done");
        @(posedge ref_clk);
        ctrl.chipEnable <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            lfsrReg = nextLfsr(lfsrReg);
            convert(i[0], i == 0 ? 12'hFFF : i == 1 ? 12'h000 : lfsrReg[11:0]);
        end
        completeRun();
    end
endmodule : sacs_sequencer_tb
bind sacs_sequencer sacs_sequencer_properties sacs_sequencer_properties_inst (.ref_clk(ref_clk),
    .arst_n(arst_n), .ctrl(ctrl), .convClkEn(convClkEn), .sampleConnect(sampleConnect),
    .capacitiveDac(capacitiveDac), .conversionStatus(conversionStatus), .dataOutEnN(dataOutEnN));
`default_nettype wire
